// ===== design/astc_pkg.sv
// package: register map, field layout and shared types of the sample timing block
package astc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SETUP1 = 6'h01;
  localparam logic [5:0] IDX_SETUP3 = 6'h03;
  localparam logic [5:0] IDX_ACYC_RST = 6'h05;
  localparam logic [5:0] IDX_SETUP4 = 6'h06;
  localparam logic [5:0] IDX_SETUP5 = 6'h08;
  localparam logic [5:0] IDX_SETUP6 = 6'h09;
  localparam logic [5:0] IDX_STATUS = 6'h10;

  // reset values
  localparam logic [7:0] RST_SETUP1 = 8'h03;
  localparam logic [7:0] RST_SETUP3 = 8'h1F;
  localparam logic [7:0] RST_SETUP4 = 8'h00;
  localparam logic [7:0] RST_SETUP5 = 8'h00;
  localparam logic [7:0] RST_SETUP6 = 8'h00;

  // writable bits of the partly reserved registers
  localparam logic [7:0] MASK_SETUP5 = 8'h1F;
  localparam logic [7:0] MASK_SETUP6 = 8'h0F;

  // setup register one fields
  localparam int S1_EN = 0;
  localparam int S1_CDS = 1;
  localparam int S1_MONO = 2;
  localparam int S1_SELECTIVE_POWERDOWN_ENABLE = 3;
  // setup register three field, mono_input_select at [7:6]
  localparam int S3_CHAN_LO = 6;
  // setup register four fields
  localparam int S4_LBL = 0;
  localparam int S4_ACYC = 1;
  localparam int S4_FME = 2;
  localparam int S4_INTM_LO = 4;
  localparam int S4_FM_LO = 6;
  // setup register five fields
  localparam int S5_DET = 0;
  localparam int S5_DEL_LO = 1;
  localparam int S5_POL = 4;

  // colour codes used by every selector
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_BLUE = 2'h2;

  // power block positions
  localparam int BLK_RED = 0;
  localparam int BLK_GREEN = 1;
  localparam int BLK_BLUE = 2;
  localparam int BLK_ADC = 3;

  // delay line length
  localparam int DELAY_W = 3;
  localparam int DELAY_TAPS = 8;

  // decoded configuration
  typedef struct packed {
    logic en;
    logic selective_powerdown_enable;
    logic mono;
    logic [1:0] chan;
    logic [1:0] fm;
    logic [1:0] intm;
    logic forced_input_enable;
    logic acyc;
    logic lbl;
    logic det;
    logic pol;
    logic [DELAY_W-1:0] vdel;
    logic [3:0] mask;
  } astc_cfg_s;

  // analogue path selection handed to the front end
  typedef struct packed {
    logic [3:0] block_power;
    logic single_channel;
    logic [1:0] input_sel;
    logic [1:0] gain_sel;
  } astc_path_s;

  // auto-cycle position
  typedef enum logic [2:0] {
    CYC_RED = 3'b001,
    CYC_GREEN = 3'b010,
    CYC_BLUE = 3'b100
  } astc_colour_e;

endpackage

// ===== design/astc_sync_detect.sv
// sync pin synchroniser, edge detector and programmable delay line
`timescale 1ns/1ns
module astc_sync_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // pin and controls
  input wire logic sync_pin,
  input wire logic sync_edge_detect_enable,
  input wire logic sync_edge_polarity,
  input wire logic [astc_pkg::DELAY_W-1:0] sync_pulse_delay,
  // timing pulse to the sample logic
  output logic timing_sync
);
  import astc_pkg::*;

  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic edge_hit;
  logic [DELAY_TAPS-1:0] dline;

  // two-stage synchroniser plus a history stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else if (pclk_en) begin
      sync_s1 <= sync_pin;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  // chosen edge gives one single-cycle pulse
  assign edge_hit = sync_edge_polarity ? (sync_s2 & ~sync_s3)
                                       : (~sync_s2 & sync_s3);

  // first tap holds the undelayed pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dline[0] <= 1'b0;
    end else if (pclk_en) begin
      dline[0] <= edge_hit & sync_edge_detect_enable;
    end
  end

  // delay taps
  genvar gi;
  generate
    for (gi = 1; gi < DELAY_TAPS; gi++) begin : g_tap
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dline[gi] <= 1'b0;
        end else if (pclk_en) begin
          dline[gi] <= dline[gi-1];
        end
      end
    end
  endgenerate

  // internal pulse replaces the pin when detection is on
  assign timing_sync = sync_edge_detect_enable ? dline[sync_pulse_delay]
                                               : sync_s2;

  a_pulse_one_wide: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && dline[0]) ##1 pclk_en |-> !dline[0])
    else $error("internal sync pulse wider than one cycle");

  a_delay_three: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && sync_edge_detect_enable && sync_pulse_delay == 3'h3) [*4]
    |-> timing_sync == $past(dline[0], 3))
    else $error("delayed pulse not three cycles after edge");

  a_rise_detect: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && sync_edge_detect_enable && sync_edge_polarity
     && sync_s2 && !sync_s3) |=> dline[0])
    else $error("rising edge produced no internal pulse");

endmodule

// ===== design/astc_ctrl.sv
// sample timing, power and colour selection control with APB registers
// Operation
// - sync pulse one cycle wide; sample taken on first edge after it falls.
// - edge-detect mode makes internal pulse from chosen sync edge polarity.
// - internal pulse delayed by three-bit count; zero means no delay.
// - with detection on, internal pulse drives sampling instead of pin.
// - without selective mode, global bit powers everything down or up.
// - selective mode ignores global bit; masked blocks are disabled.
// - registers keep values and bus stays live in any power-down state.
// - line-sequential mode powers down green, blue and forces red single path.
// - cycle pin rising edge advances multiplexers in auto-cycle mode.
// - no force, no auto: input and gain follow internal colour select.
// - auto-cycle without force steps input and gain red, green, blue.
// - force without auto: input from forced field, gain from internal.
// - force with auto: input from forced field, gain auto-cycles.
// - pixel-interleaved needs 6:1 clock ratio and setup one 03 or 01.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
module astc_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor pins
  input wire logic pixel_sample_sync,
  input wire logic clamp_or_cycle_pin,
  // front end controls
  output astc_pkg::astc_path_s path,
  output logic sample_strobe
);
  import astc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when an aligned address names a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    is_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:8] == '0) &&
                (idx == IDX_SETUP1 || idx == IDX_SETUP3 ||
                 idx == IDX_ACYC_RST || idx == IDX_SETUP4 ||
                 idx == IDX_SETUP5 || idx == IDX_SETUP6 ||
                 idx == IDX_STATUS);
  endfunction

  // colour code of an auto-cycle position
  function automatic logic [1:0] colour_code(input astc_colour_e c);
    unique case (c)
      CYC_GREEN: colour_code = COL_GREEN;
      CYC_BLUE: colour_code = COL_BLUE;
      default: colour_code = COL_RED;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] setup1_reg;
  logic [7:0] setup3_reg;
  logic [7:0] setup4_reg;
  logic [7:0] setup5_reg;
  logic [7:0] setup6_reg;
  logic ready_reg;
  logic [31:0] prdata_reg;
  logic setup_ph;
  logic access_done;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic acyc_rst_wr;
  astc_cfg_s cfg;

  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & ready_reg & pclk_en;
  assign wr_fire = access_done & pwrite & is_mapped(paddr);
  assign wr_idx = paddr[7:2];
  assign acyc_rst_wr = wr_fire & (wr_idx == IDX_ACYC_RST);

  // control registers; nothing here depends on power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup1_reg <= RST_SETUP1;
      setup3_reg <= RST_SETUP3;
      setup4_reg <= RST_SETUP4;
      setup5_reg <= RST_SETUP5;
      setup6_reg <= RST_SETUP6;
    end else if (wr_fire) begin
      unique case (wr_idx)
        IDX_SETUP1: setup1_reg <= pwdata[7:0];
        IDX_SETUP3: setup3_reg <= pwdata[7:0];
        IDX_SETUP4: setup4_reg <= pwdata[7:0];
        IDX_SETUP5: setup5_reg <= pwdata[7:0] & MASK_SETUP5;
        IDX_SETUP6: setup6_reg <= pwdata[7:0] & MASK_SETUP6;
        default: ;
      endcase
    end
  end

  // field view of the registers
  assign cfg.en = setup1_reg[S1_EN];
  assign cfg.selective_powerdown_enable = setup1_reg[S1_SELECTIVE_POWERDOWN_ENABLE];
  assign cfg.mono = setup1_reg[S1_MONO];
  assign cfg.chan = setup3_reg[S3_CHAN_LO +: 2];
  assign cfg.fm = setup4_reg[S4_FM_LO +: 2];
  assign cfg.intm = setup4_reg[S4_INTM_LO +: 2];
  assign cfg.forced_input_enable = setup4_reg[S4_FME];
  assign cfg.acyc = setup4_reg[S4_ACYC];
  assign cfg.lbl = setup4_reg[S4_LBL];
  assign cfg.det = setup5_reg[S5_DET];
  assign cfg.pol = setup5_reg[S5_POL];
  assign cfg.vdel = setup5_reg[S5_DEL_LO +: DELAY_W];
  assign cfg.mask = setup6_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  astc_colour_e colour_reg;
  logic [7:0] sample_cnt_reg;

  // read word of each register; status holds path state, cycle position and sample count
  function automatic logic [31:0] read_word(input logic [5:0] idx,
                                            input astc_path_s p,
                                            input logic [1:0] cc,
                                            input logic [7:0] cnt);
    unique case (idx)
      IDX_SETUP1: read_word = {24'h000000, setup1_reg};
      IDX_SETUP3: read_word = {24'h000000, setup3_reg};
      IDX_SETUP4: read_word = {24'h000000, setup4_reg};
      IDX_SETUP5: read_word = {24'h000000, setup5_reg};
      IDX_SETUP6: read_word = {24'h000000, setup6_reg};
      IDX_STATUS: read_word = {13'h0000, cnt, p, cc};
      default: read_word = 32'h00000000;
    endcase
  endfunction

  // read data captured in the setup cycle, ready one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else if (pclk_en) begin
      if (setup_ph) begin
        ready_reg <= 1'b1;
        prdata_reg <= is_mapped(paddr) ? read_word(paddr[7:2], path,
          colour_code(colour_reg), sample_cnt_reg) : 32'h00000000;
      end else if (access_done) begin
        ready_reg <= 1'b0;
      end
    end
  end

  assign pready = ready_reg & pclk_en;
  assign prdata = prdata_reg;
  assign pslverr = pready & penable & psel & ~is_mapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // sample timing

  logic timing_sync;
  logic ts_prev;
  logic sample_reg;

  astc_sync_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .sync_pin(pixel_sample_sync),
    .sync_edge_detect_enable(cfg.det),
    .sync_edge_polarity(cfg.pol),
    .sync_pulse_delay(cfg.vdel),
    .timing_sync(timing_sync)
  );

  // sample strobe on the first edge after the timing pulse is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_prev <= 1'b0;
      sample_reg <= 1'b0;
    end else if (pclk_en) begin
      ts_prev <= timing_sync;
      sample_reg <= ts_prev & ~timing_sync;
    end
  end

  // running count of samples, readable in status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt_reg <= 8'h00;
    end else if (pclk_en && sample_reg) begin
      sample_cnt_reg <= sample_cnt_reg + 8'h01;
    end
  end

  assign sample_strobe = sample_reg;

  ////////////////////////////////////////////////////////////////////////////
  // auto-cycle

  logic cyc_s1;
  logic cyc_s2;
  logic cyc_s3;
  logic cyc_rise;
  logic cyc_step;

  // cycle pin synchroniser and history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_s1 <= 1'b0;
      cyc_s2 <= 1'b0;
      cyc_s3 <= 1'b0;
    end else if (pclk_en) begin
      cyc_s1 <= clamp_or_cycle_pin;
      cyc_s2 <= cyc_s1;
      cyc_s3 <= cyc_s2;
    end
  end

  assign cyc_rise = cyc_s2 & ~cyc_s3;
  assign cyc_step = cyc_rise & cfg.lbl & cfg.acyc;

  // colour position; a reset write takes priority over a step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      colour_reg <= CYC_RED;
    end else if (pclk_en) begin
      if (acyc_rst_wr) begin
        colour_reg <= CYC_RED;
      end else if (cyc_step) begin
        unique case (colour_reg)
          CYC_RED: colour_reg <= CYC_GREEN;
          CYC_GREEN: colour_reg <= CYC_BLUE;
          CYC_BLUE: colour_reg <= CYC_RED;
          default: colour_reg <= CYC_RED;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power and path selection

  astc_path_s path_next;
  logic [1:0] auto_code;

  assign auto_code = colour_code(colour_reg);

  // power map and multiplexer choice
  always_comb begin
    path_next = '0;
    if (cfg.selective_powerdown_enable) begin
      path_next.block_power = ~cfg.mask;
    end else begin
      path_next.block_power = {4{cfg.en}};
    end
    if (cfg.lbl) begin
      path_next.block_power[BLK_GREEN] = 1'b0;
      path_next.block_power[BLK_BLUE] = 1'b0;
      path_next.single_channel = 1'b1;
      if (cfg.forced_input_enable) begin
        path_next.input_sel = cfg.fm;
      end else if (cfg.acyc) begin
        path_next.input_sel = auto_code;
      end else begin
        path_next.input_sel = cfg.intm;
      end
      path_next.gain_sel = cfg.acyc ? auto_code : cfg.intm;
    end else if (cfg.mono) begin
      path_next.single_channel = 1'b1;
      path_next.input_sel = cfg.chan;
      path_next.gain_sel = cfg.chan;
    end else begin
      path_next.input_sel = COL_RED;
      path_next.gain_sel = COL_RED;
    end
  end

  // registered path outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path <= '0;
    end else if (pclk_en) begin
      path <= path_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_sample_after_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    (pclk_en && timing_sync) ##1 (pclk_en && !timing_sync)
    |=> sample_strobe)
    else $error("no sample after timing pulse ended");

  a_power_global: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && !cfg.selective_powerdown_enable && !cfg.lbl) ##1 $stable(setup1_reg)
    |-> path.block_power == {4{cfg.en}})
    else $error("global power state not applied");

  a_power_select: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && cfg.selective_powerdown_enable) ##1 ($stable(setup6_reg) && cfg.selective_powerdown_enable)
    |-> (path.block_power & cfg.mask) == 4'h0)
    else $error("masked block still powered");

  a_line_seq_red: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && cfg.lbl) |=> (!path.block_power[BLK_GREEN]
    && !path.block_power[BLK_BLUE] && path.single_channel))
    else $error("line-sequential mode left green or blue on");

  a_cycle_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && cyc_step && !acyc_rst_wr && colour_reg == CYC_BLUE)
    |=> colour_reg == CYC_RED)
    else $error("auto-cycle did not wrap blue to red");

  a_intm_select: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && cfg.lbl && !cfg.forced_input_enable && !cfg.acyc) ##1 $stable(setup4_reg)
    |-> path.input_sel == cfg.intm && path.gain_sel == cfg.intm)
    else $error("internal colour select not applied");

  a_forced_input: assert property (@(posedge pclk) disable iff (!presetn)
    (pclk_en && cfg.lbl && cfg.forced_input_enable) ##1 $stable(setup4_reg)
    |-> path.input_sel == cfg.fm)
    else $error("forced input select not applied");

endmodule

// ===== sim/astc_sensor_model.sv
// sensor timing generator model driving the sync and cycle pins
`timescale 1ns/1ns
module astc_sensor_model (
  // clock
  input wire logic pclk,
  // pins towards the block, driven low between frames
  output logic pixel_sample_sync,
  output logic clamp_or_cycle_pin
);
  // both pins idle low until a task drives them
  initial begin
    pixel_sample_sync = 1'b0;
    clamp_or_cycle_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // n pulses w cycles wide every p cycles; entered at a rising edge
  task automatic pulses(input int w, input int p, input int n);
    for (int i = 0; i < n; i++) begin
      pixel_sample_sync <= 1'b1;
      repeat (w) @(posedge pclk);
      pixel_sample_sync <= 1'b0;
      repeat (p - w) @(posedge pclk);
    end
  endtask

  // one cycle pulse on the cycle pin; entered at a rising edge
  task automatic cycle_pulse();
    clamp_or_cycle_pin <= 1'b1;
    @(posedge pclk);
    clamp_or_cycle_pin <= 1'b0;
  endtask
endmodule

// ===== sim/astc_ctrl_tb_top.sv
// self-checking bench for the sample timing and colour control block
`timescale 1ns/1ns
module astc_ctrl_tb_top;
  import astc_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } astc_tb_rd_s;
  logic pclk, presetn, pclk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q;
  logic pready, pslverr, sync_pin, cyc_pin, sample_strobe;
  astc_path_s path;
  int cyc, failures, n_tests, n_samp;
  int sq[$];
  astc_tb_rd_s rq[$];
  logic [7:0] s1, s3, s4, s6;
  logic [1:0] col;

  // block and sensor model
  astc_ctrl u_astc_ctrl (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_sample_sync(sync_pin), .clamp_or_cycle_pin(cyc_pin),
    .path(path), .sample_strobe(sample_strobe));
  astc_sensor_model u_astc_sensor_model (.pclk(pclk),
    .pixel_sample_sync(sync_pin), .clamp_or_cycle_pin(cyc_pin));

  // 40 ns clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic bad(input string msg);
    failures++;
    $display("BAD t=%0t %s", $time, msg);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp_rd(input astc_tb_rd_s r);
    n_tests++;
    if ((prdata & r.m) !== (r.d & r.m) || pslverr !== r.e) bad("rd");
  endtask

  // cycle count, the watcher that pops expected results, and hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sample_strobe === 1'b1) begin
      n_tests++;
      if (sq.size() == 0) bad("stray strobe");
      else if (sq.pop_front() != cyc) bad("strobe time");
    end
    if (psel && penable && pready === 1'b1) begin
      if (rq.size() == 0) bad("stray transfer");
      else cmp_rd(rq.pop_front());
    end
    if (cyc == 20000) begin
      bad("timeout");
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer, entered at a rising edge; holds until pready
  task automatic apb(input logic w, input logic [5:0] idx,
      input logic [7:0] wd, input logic [31:0] ed, input logic [31:0] m,
      input logic e);
    rq.push_back('{ed, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 8'h0, {24'h0, v}, 32'hFFFFFFFF, 1'b0);
  endtask

  // write and keep the bench copy of the configuration
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v, 32'h0, 32'h0, 1'b0);
    case (idx)
      IDX_SETUP1: s1 = v;
      IDX_SETUP3: s3 = v;
      IDX_SETUP4: s4 = v;
      IDX_SETUP6: s6 = v;
      IDX_ACYC_RST: col = COL_RED;
      default: ;
    endcase
  endtask

  // expected path from the bench copy of the configuration
  function automatic astc_path_s exp_path();
    astc_path_s p;
    logic [1:0] g;
    p.block_power = s1[S1_SELECTIVE_POWERDOWN_ENABLE] ? ~s6[3:0] : {4{s1[S1_EN]}};
    p.single_channel = s4[S4_LBL] | s1[S1_MONO];
    g = s4[S4_ACYC] ? col : s4[S4_INTM_LO +: 2];
    p.gain_sel = g;
    p.input_sel = s4[S4_FME] ? s4[S4_FM_LO +: 2] : g;
    if (s4[S4_LBL]) begin
      p.block_power[BLK_GREEN] = 1'b0;
      p.block_power[BLK_BLUE] = 1'b0;
    end else begin
      p.input_sel = s1[S1_MONO] ? s3[7:6] : COL_RED;
      p.gain_sel = p.input_sel;
    end
    return p;
  endfunction

  // path on the port and in the status register
  task automatic check_path();
    astc_path_s e;
    e = exp_path();
    repeat (6) @(posedge pclk);
    n_tests++;
    if (path !== e) bad("path");
    apb(1'b0, IDX_STATUS, 8'h0, {21'h0, e, col}, 32'h7FF, 1'b0);
  endtask

  // sync pulses in pin or edge mode, expected strobe cycles queued first
  task automatic sync_run(input int w, input int p, input int n,
      input logic det, input logic pol, input int d);
    n_samp += n;
    wr(IDX_SETUP5, {3'h0, pol, d[2:0], det});
    for (int i = 0; i < n; i++) begin
      if (!det) sq.push_back(cyc + p * i + w + 4);
      else sq.push_back(cyc + p * i + (pol ? 0 : w) + 6 + d);
    end
    u_astc_sensor_model.pulses(w, p, n);
    repeat (24) @(posedge pclk);
    n_tests++;
    if (sq.size() != 0) bad("missing strobe");
    sq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    pclk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lfsr_q = 32'h924703CC;
    s1 = RST_SETUP1;
    s3 = RST_SETUP3;
    s4 = RST_SETUP4;
    s6 = RST_SETUP6;
    col = COL_RED;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_SETUP1, RST_SETUP1);
    rd(IDX_SETUP3, RST_SETUP3);
    rd(IDX_SETUP4, RST_SETUP4);
    rd(IDX_SETUP5, RST_SETUP5);
    rd(IDX_SETUP6, RST_SETUP6);
    rd(IDX_ACYC_RST, 8'h00);
    apb(1'b0, 6'h02, 8'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(IDX_SETUP5, 8'hFF);
    rd(IDX_SETUP5, MASK_SETUP5);
    wr(IDX_SETUP6, 8'hFF);
    check_path();
    $display("test registers done");
    wr(IDX_SETUP1, 8'h02);
    check_path();
    rd(IDX_SETUP6, MASK_SETUP6);
    wr(IDX_SETUP1, 8'h03);
    check_path();
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      wr(IDX_SETUP6, lfsr_q[7:0]);
      wr(IDX_SETUP1, {4'h0, 1'b1, 2'h1, lfsr_q[8]});
      check_path();
    end
    $display("test power done");
    wr(IDX_SETUP1, 8'h07);
    for (int c = 0; c < 3; c++) begin
      wr(IDX_SETUP3, {c[1:0], 6'h1F});
      check_path();
    end
    wr(IDX_SETUP1, 8'h03);
    check_path();
    $display("test mono done");
    for (int m = 0; m < 4; m++) begin
      lfsr_q = lfsr(lfsr_q);
      wr(IDX_ACYC_RST, 8'h00);
      wr(IDX_SETUP4, {lfsr_q[3:0], 1'b0, m[1:0], 1'b1});
      check_path();
      for (int k = 0; k < 3; k++) begin
        u_astc_sensor_model.cycle_pulse();
        if (m[0]) col = (col == COL_BLUE) ? COL_RED : col + 2'h1;
        check_path();
      end
    end
    wr(IDX_SETUP4, 8'h00);
    $display("test colour select done");
    sync_run(1, 6, 4, 1'b0, 1'b0, 0);
    wr(IDX_SETUP3, 8'h0F);
    sync_run(1, 3, 5, 1'b0, 1'b0, 0);
    wr(IDX_SETUP1, 8'h45);
    sync_run(1, 2, 6, 1'b0, 1'b0, 0);
    sync_run(3, 8, 3, 1'b0, 1'b0, 0);
    $display("test pin sync done");
    wr(IDX_SETUP1, 8'h03);
    for (int i = 0; i < 4; i++) begin
      sync_run(4, 8, 3, 1'b1, i[0], i[1] ? 7 : 0);
    end
    sync_run(3, 6, 4, 1'b1, 1'b1, 3);
    sync_run(3, 6, 4, 1'b1, 1'b0, 7);
    $display("test edge sync done");
    apb(1'b0, IDX_STATUS, 8'h0, {13'h0, n_samp[7:0], 11'h0}, 32'h7F800,
      1'b0);
    summarize();
  end
endmodule
